// File: hdl/pwm_timer_pkg.sv
// Constants and types shared by the four-channel PWM timer control block
package pwm_timer_pkg;

    localparam int NUM_CH = 4;
    localparam int CNT_W = 16;
    localparam int NUM_CCR = 6;
    localparam int NUM_EV = 9;
    localparam int NUM_IN = 3;
    localparam int NUM_OPS = 3;
    localparam int ADDR_W = 9;
    localparam int CTRL_W = 23;

    // Global registers, byte addresses
    localparam logic [ADDR_W-1:0] ADDR_START_STOP = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_RUN = 9'h004;
    localparam logic [ADDR_W-1:0] ADDR_EXT_STATUS = 9'h008;
    localparam logic [ADDR_W-1:0] ADDR_EXT_CLEAR = 9'h00c;
    localparam logic [ADDR_W-1:0] ADDR_EXT_ENABLE = 9'h010;

    // Channel n block sits at 0x40*(n+1); offsets inside a block
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_CNT = 6'h04;
    localparam logic [5:0] OFF_PERIOD = 6'h08;
    localparam logic [5:0] OFF_CCR_A = 6'h0c;
    localparam logic [5:0] OFF_CCR_F = 6'h20;
    localparam logic [5:0] OFF_DVU = 6'h24;
    localparam logic [5:0] OFF_DVD = 6'h28;
    localparam logic [5:0] OFF_STATUS = 6'h2c;
    localparam logic [5:0] OFF_CLEAR = 6'h30;
    localparam logic [5:0] OFF_ENABLE = 6'h34;

    // Start/stop register fields
    localparam int START_LSB = 0;
    localparam int STOP_LSB = 4;

    // Channel control fields
    localparam int CTRL_TRI = 0;
    localparam int CTRL_DOWN = 1;
    localparam int CTRL_AUTO_DT = 2;
    localparam int CTRL_DVU_BUF = 3;
    localparam int CTRL_DVD_BUF = 4;
    localparam int CTRL_MIRROR = 5;
    localparam int CTRL_SW_CLEAR = 6;
    localparam int CTRL_HW_LSB = 8;
    localparam int CTRL_HW_STRIDE = 5;
    localparam int CTRL_EDGE_OFS = 3;

    // Channel event bits and external trigger status bits
    localparam int EV_CMP_A = 0;
    localparam int EV_CMP_B = 1;
    localparam int EV_DEAD = 6;
    localparam int EV_OVF = 7;
    localparam int EV_UNF = 8;
    localparam int EXT_FALL = 0;
    localparam int EXT_RISE = 1;

    // Synchronised input positions and hardware operations
    localparam int IN_PIN_A = 0;
    localparam int IN_PIN_B = 1;
    localparam int IN_EXT = 2;
    localparam int OP_START = 0;
    localparam int OP_STOP = 1;
    localparam int OP_CLEAR = 2;

    // Values after reset
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
    localparam logic waitReqRst = 1'b1;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_PIN_A = 3'h1,
        SRC_PIN_B = 3'h2,
        SRC_CMP_A = 3'h3,
        SRC_CMP_B = 3'h4,
        SRC_EXT = 3'h5
    } hw_src_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;

endpackage

// File: hdl/pwm_timer_channel_control.sv
// Four-channel PWM timer control with Avalon-MM register slave
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
module pwm_timer_channel_control
    import pwm_timer_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic ch3PinA,
    input wire logic ch3PinB,
    input wire logic externalTriggerPin,
    output logic irq,
    output logic [NUM_CH-1:0] counterRunning
);

    typedef struct packed {
        logic waitReq;
        logic [31:0] rdata;
        logic irq;
        logic [NUM_CH-1:0] running;
        count_dir_t [NUM_CH-1:0] dir;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt, period, dvu, dvd, dvuBuf, dvdBuf;
        logic [NUM_CH-1:0][NUM_CCR-1:0][CNT_W-1:0] ccr;
        logic [NUM_CH-1:0][CTRL_W-1:0] ctrl;
        logic [NUM_CH-1:0][NUM_EV-1:0] evStatus, evEnable;
        logic [1:0] extStatus, extEnable;
        logic [NUM_IN-1:0] syncFirst, syncSecond, inPrev;
        logic [2:0] syncValid;
        logic [1:0] cmpOut, cmpPrev;
        logic [NUM_CH-1:0][NUM_OPS-1:0] hwPend;
    } state_t;

    state_t stateReg;
    state_t stateNext;

    logic acc;
    logic wrAcc;
    logic [31:0] beMask;
    logic [31:0] wrBits;
    logic [2:0] chField;
    logic chHit;
    logic [1:0] chSel;
    logic [5:0] offs;
    logic [2:0] ccrIdx;
    logic ccrHit;

    logic [NUM_CH-1:0] swStart;
    logic [NUM_CH-1:0] swStop;
    logic [NUM_CH-1:0] swGo;
    logic [NUM_CH-1:0] swHalt;
    logic [4:0] lvCur;
    logic [4:0] lvPrev;
    logic [1:0] extEv;
    logic primed;
    logic [CTRL_W-1:0] ctrlC;
    logic triMode;
    logic chWr;
    logic run;
    logic autoOn;
    logic dtErr;
    logic xfer;
    logic [NUM_EV-1:0] ev;
    logic [CNT_W-1:0] cntN;
    logic [CNT_W-1:0] cntC;
    logic [CNT_W-1:0] wrVal;
    count_dir_t dirN;
    logic [CNT_W:0] sumUp;
    logic [CNT_W:0] diffDn;
    hw_src_t src;
    edge_sel_t edgeSel;
    logic [31:0] rdMux;
    logic irqAny;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    function automatic logic srcLevel(input hw_src_t s, input logic [4:0] lv);
        logic r;
        r = 1'b0;
        case (s)
            SRC_PIN_A: r = lv[0];
            SRC_PIN_B: r = lv[1];
            SRC_CMP_A: r = lv[2];
            SRC_CMP_B: r = lv[3];
            SRC_EXT: r = lv[4];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic qualify(input logic cur, input logic prev, input edge_sel_t e);
        logic r;
        r = 1'b0;
        case (e)
            EDGE_RISE: r = cur & ~prev;
            EDGE_FALL: r = ~cur & prev;
            EDGE_BOTH: r = cur ^ prev;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // One wait cycle per request keeps read data a registered copy
    assign acc = (read | write) & ~stateReg.waitReq;
    assign wrAcc = write & acc;
    assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wrBits = writedata & beMask;
    assign chField = address[8:6];
    assign chHit = (chField != 3'h0) && (chField <= 3'h4);
    assign chSel = 2'(chField - 3'h1);
    assign offs = address[5:0];
    assign ccrHit = (offs >= OFF_CCR_A) && (offs <= OFF_CCR_F) && (offs[1:0] == 2'h0);
    assign ccrIdx = 3'((offs - OFF_CCR_A) >> 2);

    always_comb
    begin
        stateNext = stateReg;
        swStart = '0;
        swStop = '0;
        ctrlC = '0;
        triMode = 1'b0;
        chWr = 1'b0;
        run = 1'b0;
        autoOn = 1'b0;
        dtErr = 1'b0;
        xfer = 1'b0;
        ev = '0;
        cntN = '0;
        cntC = '0;
        wrVal = '0;
        dirN = DIR_UP;
        sumUp = '0;
        diffDn = '0;
        src = SRC_NONE;
        edgeSel = EDGE_NONE;
        rdMux = '0;
        irqAny = 1'b0;

        stateNext.waitReq = ~((read | write) & stateReg.waitReq);

        // First stage feeds only the second; edges are taken after it
        stateNext.syncFirst = {externalTriggerPin, ch3PinB, ch3PinA};
        stateNext.syncSecond = stateReg.syncFirst;
        // Edges wait for real pin levels, else a pin idling high fakes a rise after reset
        stateNext.syncValid = {stateReg.syncValid[1:0], 1'b1};
        primed = stateReg.syncValid[2];
        stateNext.inPrev = stateReg.syncSecond;
        stateNext.cmpPrev = stateReg.cmpOut;
        lvCur = {stateReg.syncSecond[IN_EXT], stateReg.cmpOut, stateReg.syncSecond[IN_PIN_B:IN_PIN_A]};
        lvPrev = {stateReg.inPrev[IN_EXT], stateReg.cmpPrev, stateReg.inPrev[IN_PIN_B:IN_PIN_A]};

        extEv[EXT_RISE] = primed & stateReg.syncSecond[IN_EXT] & ~stateReg.inPrev[IN_EXT];
        extEv[EXT_FALL] = primed & ~stateReg.syncSecond[IN_EXT] & stateReg.inPrev[IN_EXT];

        if (wrAcc && address == ADDR_START_STOP)
        begin
            swStart = wrBits[START_LSB +: NUM_CH];
            swStop = wrBits[STOP_LSB +: NUM_CH];
        end
        // A channel named for both start and stop is left alone
        swGo = swStart & ~swStop;
        swHalt = swStop & ~swStart;

        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            ctrlC = stateReg.ctrl[ch];
            triMode = ctrlC[CTRL_TRI];
            chWr = wrAcc && chHit && (chSel == 2'(ch));
            ev = '0;

            for (int op = 0; op < NUM_OPS; op++)
            begin
                src = hw_src_t'(ctrlC[CTRL_HW_LSB + op * CTRL_HW_STRIDE +: 3]);
                edgeSel = edge_sel_t'(ctrlC[CTRL_HW_LSB + op * CTRL_HW_STRIDE + CTRL_EDGE_OFS +: 2]);
                // Own compare outputs would loop back on channel 3, so they read as no source
                if (ch == NUM_CH - 1 && (src == SRC_CMP_A || src == SRC_CMP_B))
                begin
                    src = SRC_NONE;
                end
                stateNext.hwPend[ch][op] = primed & qualify(srcLevel(src, lvCur), srcLevel(src, lvPrev), edgeSel);
            end

            // Hardware stop beats start; software acts on top in the same cycle
            run = stateReg.running[ch];
            if (stateReg.hwPend[ch][OP_STOP])
            begin
                run = 1'b0;
            end
            else if (stateReg.hwPend[ch][OP_START])
            begin
                run = 1'b1;
            end
            if (swGo[ch])
            begin
                run = 1'b1;
            end
            else if (swHalt[ch])
            begin
                run = 1'b0;
            end
            stateNext.running[ch] = run;

            cntC = stateReg.cnt[ch];
            cntN = cntC;
            dirN = stateReg.dir[ch];
            if (stateReg.running[ch])
            begin
                for (int k = 0; k < NUM_CCR; k++)
                begin
                    if (cntC == stateReg.ccr[ch][k])
                    begin
                        ev[k] = 1'b1;
                    end
                end
                if (!triMode)
                begin
                    if (ctrlC[CTRL_DOWN])
                    begin
                        if (cntC == '0)
                        begin
                            cntN = stateReg.period[ch];
                            ev[EV_UNF] = 1'b1;
                        end
                        else
                        begin
                            cntN = CNT_W'(cntC - 1'b1);
                        end
                    end
                    else if (cntC >= stateReg.period[ch])
                    begin
                        cntN = '0;
                        ev[EV_OVF] = 1'b1;
                    end
                    else
                    begin
                        cntN = CNT_W'(cntC + 1'b1);
                    end
                end
                else if (dirN == DIR_UP)
                begin
                    if (cntC >= stateReg.period[ch])
                    begin
                        dirN = DIR_DOWN;
                        cntN = (cntC == '0) ? cntC : CNT_W'(cntC - 1'b1);
                        ev[EV_OVF] = 1'b1;
                    end
                    else
                    begin
                        cntN = CNT_W'(cntC + 1'b1);
                    end
                end
                else if (cntC == '0)
                begin
                    dirN = DIR_UP;
                    cntN = CNT_W'(cntC + 1'b1);
                    ev[EV_UNF] = 1'b1;
                end
                else
                begin
                    cntN = CNT_W'(cntC - 1'b1);
                end
            end

            if (stateReg.hwPend[ch][OP_CLEAR] || (chWr && offs == OFF_CTRL && wrBits[CTRL_SW_CLEAR]))
            begin
                cntN = '0;
                dirN = DIR_UP;
            end
            if (chWr && offs == OFF_CNT)
            begin
                cntN = CNT_W'(merge(32'(cntC), writedata, beMask));
            end
            stateNext.cnt[ch] = cntN;
            stateNext.dir[ch] = dirN;

            if (chWr)
            begin
                if (offs == OFF_CTRL)
                begin
                    // Clear bit is an action and never stored
                    stateNext.ctrl[ch] = CTRL_W'(merge(32'(ctrlC), writedata, beMask));
                    stateNext.ctrl[ch][CTRL_SW_CLEAR] = 1'b0;
                end
                else if (offs == OFF_PERIOD)
                begin
                    stateNext.period[ch] = CNT_W'(merge(32'(stateReg.period[ch]), writedata, beMask));
                end
                else if (ccrHit)
                begin
                    stateNext.ccr[ch][ccrIdx] = CNT_W'(merge(32'(stateReg.ccr[ch][ccrIdx]), writedata, beMask));
                end
                else if (offs == OFF_DVU)
                begin
                    wrVal = CNT_W'(merge(32'(stateReg.dvu[ch]), writedata, beMask));
                    if (ctrlC[CTRL_DVU_BUF])
                    begin
                        stateNext.dvuBuf[ch] = wrVal;
                    end
                    else
                    begin
                        stateNext.dvu[ch] = wrVal;
                    end
                    if (ctrlC[CTRL_MIRROR])
                    begin
                        if (ctrlC[CTRL_DVD_BUF])
                        begin
                            stateNext.dvdBuf[ch] = wrVal;
                        end
                        else
                        begin
                            stateNext.dvd[ch] = wrVal;
                        end
                    end
                end
                else if (offs == OFF_DVD)
                begin
                    wrVal = CNT_W'(merge(32'(stateReg.dvd[ch]), writedata, beMask));
                    if (ctrlC[CTRL_DVD_BUF])
                    begin
                        stateNext.dvdBuf[ch] = wrVal;
                    end
                    else
                    begin
                        stateNext.dvd[ch] = wrVal;
                    end
                end
                else if (offs == OFF_CLEAR)
                begin
                    stateNext.evStatus[ch] = stateReg.evStatus[ch] & ~wrBits[NUM_EV-1:0];
                end
                else if (offs == OFF_ENABLE)
                begin
                    stateNext.evEnable[ch] = NUM_EV'(merge(32'(stateReg.evEnable[ch]), writedata, beMask));
                end
            end

            // Buffered dead-time values move in at the end of each count cycle
            xfer = ev[EV_UNF] | (ev[EV_OVF] & ~triMode);
            if (xfer && ctrlC[CTRL_DVU_BUF])
            begin
                stateNext.dvu[ch] = stateReg.dvuBuf[ch];
            end
            if (xfer && ctrlC[CTRL_DVD_BUF])
            begin
                stateNext.dvd[ch] = stateReg.dvdBuf[ch];
            end

            // Auto value overrides a software write to B in the same cycle
            autoOn = ctrlC[CTRL_AUTO_DT] & triMode;
            sumUp = {1'b0, stateReg.ccr[ch][EV_CMP_A]} + {1'b0, stateReg.dvu[ch]};
            diffDn = {1'b0, stateReg.ccr[ch][EV_CMP_A]} - {1'b0, stateReg.dvd[ch]};
            dtErr = (stateReg.dir[ch] == DIR_UP) ? (sumUp > {1'b0, stateReg.period[ch]}) : diffDn[CNT_W];
            if (autoOn)
            begin
                if (!dtErr)
                begin
                    stateNext.ccr[ch][EV_CMP_B] = (stateReg.dir[ch] == DIR_UP) ? sumUp[CNT_W-1:0] : diffDn[CNT_W-1:0];
                end
                ev[EV_DEAD] = dtErr & stateReg.running[ch];
            end

            // An event in the clearing cycle survives the clear
            stateNext.evStatus[ch] = stateNext.evStatus[ch] | ev;

            if (ch == NUM_CH - 1)
            begin
                stateNext.cmpOut = stateReg.cmpOut ^ ev[EV_CMP_B:EV_CMP_A];
            end
            irqAny = irqAny | (|(stateNext.evStatus[ch] & stateNext.evEnable[ch]));
        end

        if (wrAcc && address == ADDR_EXT_CLEAR)
        begin
            stateNext.extStatus = stateReg.extStatus & ~wrBits[1:0];
        end
        if (wrAcc && address == ADDR_EXT_ENABLE)
        begin
            stateNext.extEnable = 2'(merge(32'(stateReg.extEnable), writedata, beMask));
        end
        stateNext.extStatus = stateNext.extStatus | extEv;
        irqAny = irqAny | (|(stateNext.extStatus & stateNext.extEnable));
        stateNext.irq = irqAny;

        // Read decode; unmapped and write-only addresses read zero
        if (address == ADDR_RUN)
        begin
            rdMux = 32'(stateReg.running);
        end
        else if (address == ADDR_EXT_STATUS)
        begin
            rdMux = 32'(stateReg.extStatus);
        end
        else if (address == ADDR_EXT_ENABLE)
        begin
            rdMux = 32'(stateReg.extEnable);
        end
        else if (chHit && offs == OFF_CTRL)
        begin
            rdMux = 32'(stateReg.ctrl[chSel]);
        end
        else if (chHit && offs == OFF_CNT)
        begin
            rdMux = 32'(stateReg.cnt[chSel]);
        end
        else if (chHit && offs == OFF_PERIOD)
        begin
            rdMux = 32'(stateReg.period[chSel]);
        end
        else if (chHit && ccrHit)
        begin
            rdMux = 32'(stateReg.ccr[chSel][ccrIdx]);
        end
        else if (chHit && offs == OFF_DVU)
        begin
            rdMux = 32'(stateReg.dvu[chSel]);
        end
        else if (chHit && offs == OFF_DVD)
        begin
            rdMux = 32'(stateReg.dvd[chSel]);
        end
        else if (chHit && offs == OFF_STATUS)
        begin
            rdMux = 32'(stateReg.evStatus[chSel]);
        end
        else if (chHit && offs == OFF_ENABLE)
        begin
            rdMux = 32'(stateReg.evEnable[chSel]);
        end
        if (read && stateReg.waitReq)
        begin
            stateNext.rdata = rdMux;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stateReg <= '0;
            stateReg.waitReq <= waitReqRst;
            stateReg.period <= {NUM_CH{PERIOD_RST}};
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    assign readdata = stateReg.rdata;
    assign waitrequest = stateReg.waitReq;
    assign irq = stateReg.irq;
    assign counterRunning = stateReg.running;

endmodule

// File: dv/pwm_timer_channel_control_asserts.sv
// Port-level assertions for the PWM timer control block
`timescale 1ns/10ps
module pwm_timer_channel_control_asserts
    import pwm_timer_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic ch3PinA,
    input wire logic ch3PinB,
    input wire logic externalTriggerPin,
    input wire logic irq,
    input wire logic [NUM_CH-1:0] counterRunning
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Start and stop of one channel in the same write cancel, so only lone bits count
    logic swAcc;
    logic [3:0] startOnly;
    logic [3:0] stopOnly;
    logic rdDone;
    assign swAcc = write && !waitrequest && address == ADDR_START_STOP && byteenable[0];
    assign startOnly = writedata[3:0] & ~writedata[7:4];
    assign stopOnly = writedata[7:4] & ~writedata[3:0];
    assign rdDone = read && !waitrequest;

    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!waitrequest |-> $past(read || write))
        else $error("waitrequest low without a request");
    a_start_sets: assert property (swAcc |=> (counterRunning & $past(startOnly)) == $past(startOnly))
        else $error("selected channel did not start");
    a_stop_clears: assert property (swAcc |=> (counterRunning & $past(stopOnly)) == 4'h0)
        else $error("selected channel did not stop");
    a_run_readback: assert property (rdDone && address == ADDR_RUN |-> readdata == {28'h0, $past(counterRunning)})
        else $error("running register differs from running outputs");
    a_action_zero: assert property (rdDone && (address == ADDR_START_STOP || address == ADDR_EXT_CLEAR)
        |-> readdata == 32'h0)
        else $error("action register read not zero");
    a_unmapped_zero: assert property (rdDone && address >= 9'h140 |-> readdata == 32'h0)
        else $error("unmapped read not zero");

    c_sw_start: cover property (swAcc && startOnly != 4'h0);
    c_hw_start: cover property ($rose(counterRunning[2]) && !$past(write));
    c_irq_seen: cover property ($rose(irq));
endmodule

// File: dv/pwm_timer_channel_control_bench.sv
// Register-level testbench for the PWM timer control block
`timescale 1ns/10ps
module pwm_timer_channel_control_bench
    import pwm_timer_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = '0;
    logic ch3PinA = 1'b0;
    logic ch3PinB = 1'b0;
    logic externalTriggerPin = 1'b1;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic [NUM_CH-1:0] counterRunning;
    logic [31:0] rdata;
    int num_errors = 0;
    int n_checks = 0;

    always #5 core_clk = ~core_clk;

    pwm_timer_channel_control pwm_timer_channel_control_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .ch3PinA(ch3PinA), .ch3PinB(ch3PinB),
        .externalTriggerPin(externalTriggerPin), .irq(irq), .counterRunning(counterRunning));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    // One bus cycle; an idle edge follows so the strobe is never reassigned in one step
    task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0)
        begin
            num_errors++;
            results();
        end
        rdata = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    // Pins pass a synchroniser, so the effect is polled under a bound
    task automatic waitRun(input logic [3:0] e);
        int n;
        n = 0;
        while (counterRunning !== e && n < 30)
        begin
            @(posedge core_clk);
            n++;
        end
        chk({28'h0, counterRunning}, {28'h0, e});
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(ADDR_RUN, 32'h0);
        rd(ADDR_EXT_STATUS, 32'h0);
        rd(9'h048, 32'hffff);
        wr(ADDR_START_STOP, 32'h5);
        chk({28'h0, counterRunning}, 32'h5);
        wr(ADDR_START_STOP, 32'h1a);
        chk({28'h0, counterRunning}, 32'he);
        wr(ADDR_START_STOP, 32'h22);
        rd(ADDR_RUN, 32'he);
        rd(ADDR_START_STOP, 32'h0);
        wr(ADDR_START_STOP, 32'he0);
        chk({28'h0, counterRunning}, 32'h0);
        $display("test start_stop done");
        wr(9'h048, 32'h100);
        wr(9'h04c, 32'h40);
        wr(9'h064, 32'h10);
        wr(9'h068, 32'h20);
        wr(9'h040, 32'h5);
        wr(ADDR_START_STOP, 32'h1);
        rd(9'h050, 32'h50);
        wr(ADDR_START_STOP, 32'h10);
        wr(9'h040, 32'h4);
        wr(9'h050, 32'h77);
        rd(9'h050, 32'h77);
        wr(9'h040, 32'h20);
        wr(9'h064, 32'h22);
        rd(9'h068, 32'h22);
        wr(9'h040, 32'h0);
        wr(9'h064, 32'h33);
        rd(9'h068, 32'h22);
        wr(9'h040, 32'ha);
        wr(9'h064, 32'h44);
        rd(9'h064, 32'h33);
        wr(ADDR_START_STOP, 32'h1);
        for (int i = 0; i < 120 && rdata != 32'h44; i++)
            acc(1'b0, 9'h064, 32'h0);
        chk(rdata, 32'h44);
        acc(1'b0, 9'h06c, 32'h0);
        chk(rdata & 32'h100, 32'h100);
        wr(ADDR_START_STOP, 32'h10);
        $display("test dead_time done");
        wr(9'h084, 32'h1234);
        rd(9'h084, 32'h1234);
        wr(9'h080, 32'h40);
        rd(9'h084, 32'h0);
        rd(9'h080, 32'h0);
        $display("test soft_clear done");
        wr(9'h088, 32'h10);
        wr(9'h0b4, 32'h180);
        wr(9'h080, 32'h1);
        wr(ADDR_START_STOP, 32'h2);
        for (int i = 0; i < 30 && (rdata & 32'h180) != 32'h180; i++)
            acc(1'b0, 9'h0ac, 32'h0);
        chk(rdata & 32'h180, 32'h180);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_START_STOP, 32'h20);
        wr(9'h0b0, 32'h1ff);
        chk({31'h0, irq}, 32'h0);
        $display("test events done");
        wr(ADDR_EXT_CLEAR, 32'h3);
        wr(ADDR_EXT_ENABLE, 32'h1);
        rd(ADDR_EXT_STATUS, 32'h0);
        // Start on pin A rise, stop on trigger fall, clear on either edge of pin B
        wr(9'h0c0, 32'h6aa900);
        ch3PinA <= 1'b1;
        waitRun(4'h4);
        wr(9'h0c4, 32'h8000);
        ch3PinB <= 1'b1;
        repeat (8) @(posedge core_clk);
        acc(1'b0, 9'h0c4, 32'h0);
        chk({31'h0, rdata < 32'h10}, 32'h1);
        externalTriggerPin <= 1'b0;
        waitRun(4'h0);
        rd(ADDR_EXT_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_EXT_CLEAR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        ch3PinA <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk({28'h0, counterRunning}, 32'h0);
        externalTriggerPin <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(ADDR_EXT_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h0);
        rd(9'h1fc, 32'h0);
        wr(9'h10c, 32'h8);
        wr(9'h104, 32'h0);
        wr(9'h0c0, 32'h1b00);
        wr(ADDR_START_STOP, 32'h8);
        waitRun(4'hc);
        $display("test hw_sources done");
        results();
    end
endmodule

bind pwm_timer_channel_control pwm_timer_channel_control_asserts pwm_timer_channel_control_asserts_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ch3PinA(ch3PinA), .ch3PinB(ch3PinB), .externalTriggerPin(externalTriggerPin), .irq(irq),
    .counterRunning(counterRunning));
